// ==== include/nvmp_pkg.sv ====
// shared constants, types and address decoding for the memory protection unit
package nvmp_pkg;

	// register word indexes; byte address is four times the index
	localparam logic [23:0] IDX_ACCESS_NV = 24'h231FFC;
	localparam logic [23:0] IDX_WRITE_NV = 24'h231FFD;
	localparam logic [23:0] IDX_PASSWORD_LO = 24'h231FFE;
	localparam logic [23:0] IDX_PASSWORD_HI = 24'h231FFF;
	localparam logic [23:0] IDX_PSET_CMD = 24'h231FF0;
	localparam logic [23:0] IDX_PSET_STATUS = 24'h231FF1;

	// access_protect_nv fields
	localparam int BIT_RESERVED = 7;
	localparam int BIT_FLASH_ACCESS = 6;
	localparam int BIT_TEST_ACCESS = 5;
	localparam int BIT_EEPROM_ACCESS = 4;
	localparam int BIT_EXT_FETCH = 3;
	localparam int PWT_MSB = 2;

	// write_protect_nv fields
	localparam int BIT_TEST_LOCK = 7;
	localparam int BIT_PASSWORD_OK = 6;
	localparam int BIT_TEST_WRITE = 5;
	localparam int BIT_EEPROM_WRITE = 4;
	localparam int SECTOR_MSB = 3;

	// protected-set command fields
	localparam int CMD_TARGET_LSB = 16;
	localparam logic [1:0] TGT_ACCESS = 2'h0;
	localparam logic [1:0] TGT_WRITE = 2'h1;
	localparam logic [1:0] TGT_PASSWORD = 2'h2;

	// delivery values of the stored copies, forced values of the working copies
	localparam logic [7:0] NV_DELIVERY = 8'hFF;
	localparam logic [7:0] ACCESS_FORCED = 8'h80;
	localparam logic [7:0] WRITE_FORCED = 8'h40;
	localparam logic [7:0] PASSWORD_READ = 8'hFF;
	localparam logic [7:0] DMA_REFUSED_DATA = 8'hFF;

	// memory map
	localparam logic [23:0] FLASH_BASE = 24'h000000;
	localparam logic [23:0] FLASH_LAST = 24'h01FFFF;
	localparam int SECTOR_SHIFT = 15;
	localparam logic [23:0] RAM_BASE = 24'h200000;
	localparam logic [23:0] RAM_LAST = 24'h200FFF;
	localparam logic [23:0] EEPROM_BASE = 24'h220000;
	localparam logic [23:0] EEPROM_LAST = 24'h2203FF;
	localparam logic [23:0] TEST_BASE = 24'h230000;
	localparam logic [23:0] TEST_LAST = 24'h231FFF;
	localparam logic [23:0] TEST_CODE_LAST = 24'h231F7F;

	typedef enum logic [2:0]
	{
		RG_FLASH = 3'h0,
		RG_TEST = 3'h1,
		RG_EEPROM = 3'h2,
		RG_RAM = 3'h3,
		RG_EXT = 3'h4
	} nvmp_region_type;

	typedef enum logic [1:0]
	{
		ST_HOLD = 2'h0,
		ST_LOAD = 2'h1,
		ST_RUN = 2'h2
	} nvmp_state_type;

	// operand access request from core or dma
	typedef struct packed
	{
		logic valid;
		logic write;
		logic dma;
		logic [23:0] addr;
	} nvmp_acc_req_type;

	// registered answer to an access request
	typedef struct packed
	{
		logic done;
		logic grant;
		logic force_ff;
	} nvmp_acc_resp_type;

	// map an address to the memory holding it
	function automatic nvmp_region_type nvmp_region(input logic [23:0] a);
		nvmp_region_type r;
		r = RG_EXT;
		if (a <= FLASH_LAST)
			r = RG_FLASH;
		else if (a >= RAM_BASE && a <= RAM_LAST)
			r = RG_RAM;
		else if (a >= EEPROM_BASE && a <= EEPROM_LAST)
			r = RG_EEPROM;
		else if (a >= TEST_BASE && a <= TEST_LAST)
			r = RG_TEST;
		return r;
	endfunction : nvmp_region

endpackage : nvmp_pkg

// ==== design/nvmp_unit.sv ====
// non-volatile memory protection unit with password test-mode lock
`timescale 1ns/1ps

module nvmp_unit
	import nvmp_pkg::*;
#(
	parameter bit ACCESS_TEMP_ALLOWED = 1'b1
)
(
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic por_i, // power-on clear of stored values
	input wire logic test_mode_i, // device is in test or programming mode
	input wire logic [23:0] fetch_addr_i, // address of the running instruction
	input wire logic [25:0] wb_adr_i, // wishbone byte address
	input wire logic [31:0] wb_dat_i, // wishbone write data
	input wire logic [3:0] wb_sel_i, // wishbone byte selects
	input wire logic wb_we_i, // wishbone write
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire nvmp_acc_req_type acc_req_i, // operand access request
	output nvmp_acc_resp_type acc_resp_o, // access verdict
	output logic test_enable_o // test modes usable
);

	// stored and working copies
	logic [7:0] nv_access;
	logic [7:0] nv_write;
	logic [7:0] nv_pw_lo;
	logic [7:0] nv_pw_hi;
	logic [7:0] access_guard;
	logic [7:0] write_guard;
	logic [1:0] pset_status;
	nvmp_state_type state;
	nvmp_state_type next_state;

	// bus decode
	logic [23:0] word_idx;
	logic bus_req;
	logic bus_wr;
	nvmp_region_type fetch_rg;
	logic pset_ok;
	logic [1:0] pset_tgt;
	logic [7:0] pset_lo;
	logic [7:0] pset_hi;
	logic pset_cmd;
	logic direct_access_wr;
	logic test_bypass;
	logic password_match;

	assign word_idx = wb_adr_i[25:2];
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr = bus_req & wb_we_i & wb_sel_i[0] & (state == ST_RUN);
	assign fetch_rg = nvmp_region(fetch_addr_i);
	assign pset_ok = (fetch_rg != RG_FLASH) && (fetch_rg != RG_TEST);
	assign pset_cmd = bus_wr && (word_idx == IDX_PSET_CMD);
	assign pset_tgt = wb_dat_i[CMD_TARGET_LSB+1:CMD_TARGET_LSB];
	assign pset_lo = wb_dat_i[7:0];
	assign pset_hi = wb_dat_i[15:8];
	assign direct_access_wr = bus_wr && (word_idx == IDX_ACCESS_NV);
	assign password_match = (pset_lo == nv_pw_lo) && (pset_hi == nv_pw_hi);

	// protections bypassed only while test mode is unlocked
	assign test_bypass = test_mode_i & test_enable_o;

	// initialisation sequence after reset
	always_comb
	begin
		case (state)
			ST_HOLD: next_state = ST_LOAD;
			ST_LOAD: next_state = ST_RUN;
			ST_RUN: next_state = ST_RUN;
			default: next_state = ST_HOLD;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= ST_HOLD;
		else
			state <= next_state;
	end

	// stored values, survive rst_i; programming only clears bits
	always_ff @(posedge clk_i)
	begin
		if (por_i)
		begin
			nv_access <= NV_DELIVERY;
			nv_write <= NV_DELIVERY;
			nv_pw_lo <= NV_DELIVERY;
			nv_pw_hi <= NV_DELIVERY;
		end
		else if (pset_cmd && pset_ok)
		begin
			case (pset_tgt)
				TGT_ACCESS:
				begin
					// zeros program guards; attempt bits untouched here
					nv_access[7:PWT_MSB+1] <= nv_access[7:PWT_MSB+1] & pset_lo[7:PWT_MSB+1];
				end
				TGT_WRITE:
				begin
					// read-only lock and ok bits cannot be written
					nv_write[BIT_TEST_WRITE:0] <= nv_write[BIT_TEST_WRITE:0]
						& pset_lo[BIT_TEST_WRITE:0];
				end
				TGT_PASSWORD:
				begin
					if (nv_write[BIT_TEST_LOCK])
					begin
						nv_pw_lo <= pset_lo;
						nv_pw_hi <= pset_hi;
						nv_write[BIT_TEST_LOCK] <= 1'b0;
					end
					else if (|nv_access[PWT_MSB:0])
					begin
						if (password_match)
							nv_write[BIT_PASSWORD_OK] <= 1'b0;
						else
							nv_access[PWT_MSB:0] <= {1'b0, nv_access[PWT_MSB:1]};
					end
				end
				default:
				begin
					nv_access <= nv_access;
				end
			endcase
		end
	end

	// working access guards: forced, loaded, then lifted or restored
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state == ST_HOLD)
			access_guard <= ACCESS_FORCED;
		else if (state == ST_LOAD)
			access_guard <= nv_access;
		else if (pset_cmd && pset_ok && pset_tgt == TGT_ACCESS)
		begin
			// zeros restore guards everywhere
			access_guard[BIT_FLASH_ACCESS:BIT_EXT_FETCH] <=
				access_guard[BIT_FLASH_ACCESS:BIT_EXT_FETCH]
				& pset_lo[BIT_FLASH_ACCESS:BIT_EXT_FETCH];
			if (ACCESS_TEMP_ALLOWED && pset_lo[BIT_EXT_FETCH]
				&& (fetch_rg == RG_EEPROM || fetch_rg == RG_RAM))
				access_guard[BIT_EXT_FETCH] <= 1'b1;
			if (ACCESS_TEMP_ALLOWED && pset_lo[BIT_EEPROM_ACCESS]
				&& fetch_rg == RG_EEPROM)
				access_guard[BIT_EEPROM_ACCESS] <= 1'b1;
		end
		else if (pset_cmd && pset_ok && pset_tgt == TGT_PASSWORD
			&& !nv_write[BIT_TEST_LOCK] && !password_match && (|access_guard[PWT_MSB:0]))
			access_guard[PWT_MSB:0] <= {1'b0, access_guard[PWT_MSB:1]};
		else if (direct_access_wr && ACCESS_TEMP_ALLOWED)
		begin
			if (wb_dat_i[BIT_FLASH_ACCESS] && fetch_rg == RG_FLASH)
				access_guard[BIT_FLASH_ACCESS] <= 1'b1;
			if (wb_dat_i[BIT_TEST_ACCESS] && fetch_rg == RG_TEST)
				access_guard[BIT_TEST_ACCESS] <= 1'b1;
		end
	end

	// working write guards and test lock state
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state == ST_HOLD)
			write_guard <= WRITE_FORCED;
		else if (state == ST_LOAD)
			write_guard <= nv_write;
		else if (pset_cmd && pset_ok && pset_tgt == TGT_WRITE)
		begin
			// test area guard only ever clears
			write_guard[BIT_TEST_WRITE] <= write_guard[BIT_TEST_WRITE]
				& pset_lo[BIT_TEST_WRITE];
			write_guard[BIT_EEPROM_WRITE] <= pset_lo[BIT_EEPROM_WRITE];
			write_guard[SECTOR_MSB:0] <= pset_lo[SECTOR_MSB:0];
		end
		else if (pset_cmd && pset_ok && pset_tgt == TGT_PASSWORD)
		begin
			if (write_guard[BIT_TEST_LOCK])
				write_guard[BIT_TEST_LOCK] <= 1'b0;
			else if (password_match && (|access_guard[PWT_MSB:0]))
				write_guard[BIT_PASSWORD_OK] <= 1'b0;
		end
	end

	// test modes usable while attempts remain and the password is either not yet set or accepted
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			test_enable_o <= 1'b0;
		else
			test_enable_o <= (state == ST_RUN) && (|access_guard[PWT_MSB:0])
				&& (write_guard[BIT_TEST_LOCK] || !write_guard[BIT_PASSWORD_OK]);
	end

	// outcome of the last protected-set command
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pset_status <= 2'h0;
		else if (pset_cmd)
			pset_status <= {!pset_ok, pset_ok};
	end

	// wishbone answer one cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_req;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h00000000;
		else if (bus_req && !wb_we_i)
		begin
			case (word_idx)
				IDX_ACCESS_NV: wb_dat_o <= {24'h000000, access_guard | ACCESS_FORCED};
				IDX_WRITE_NV: wb_dat_o <= {24'h000000, write_guard};
				IDX_PASSWORD_LO: wb_dat_o <= {24'h000000, PASSWORD_READ};
				IDX_PASSWORD_HI: wb_dat_o <= {24'h000000, PASSWORD_READ};
				IDX_PSET_STATUS: wb_dat_o <= {30'h00000000, pset_status};
				default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// access verdict
	nvmp_region_type tgt_rg;
	logic deny;
	logic [1:0] sector;

	assign tgt_rg = nvmp_region(acc_req_i.addr);
	assign sector = acc_req_i.addr[SECTOR_SHIFT+1:SECTOR_SHIFT];

	always_comb
	begin
		deny = 1'b0;
		// dma has no fetch source: flash, test and eeprom guards refuse it
		if (acc_req_i.dma)
		begin
			if ((tgt_rg == RG_FLASH && !access_guard[BIT_FLASH_ACCESS])
				|| (tgt_rg == RG_TEST && !access_guard[BIT_TEST_ACCESS])
				|| (tgt_rg == RG_EEPROM && !access_guard[BIT_EEPROM_ACCESS]))
				deny = 1'b1;
		end
		else
		begin
			if (fetch_rg == RG_EXT && tgt_rg != RG_EXT && !access_guard[BIT_EXT_FETCH])
				deny = 1'b1;
			if (tgt_rg == RG_FLASH && !access_guard[BIT_FLASH_ACCESS]
				&& fetch_rg != RG_FLASH && fetch_rg != RG_TEST)
				deny = 1'b1;
			if (tgt_rg == RG_TEST && !access_guard[BIT_TEST_ACCESS] && fetch_rg != RG_TEST)
				deny = 1'b1;
			if (tgt_rg == RG_EEPROM && !access_guard[BIT_EEPROM_ACCESS]
				&& fetch_rg != RG_FLASH && fetch_rg != RG_TEST && fetch_rg != RG_EEPROM)
				deny = 1'b1;
		end
		if (acc_req_i.write)
		begin
			if (tgt_rg == RG_TEST && (!write_guard[BIT_TEST_WRITE]
				|| acc_req_i.addr <= TEST_CODE_LAST))
				deny = 1'b1;
			if (tgt_rg == RG_EEPROM && !write_guard[BIT_EEPROM_WRITE])
				deny = 1'b1;
			if (tgt_rg == RG_FLASH && !write_guard[sector])
				deny = 1'b1;
		end
		if (test_bypass)
			deny = 1'b0;
		if (state != ST_RUN)
			deny = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			acc_resp_o <= '0;
		else
		begin
			acc_resp_o.done <= acc_req_i.valid;
			acc_resp_o.grant <= acc_req_i.valid & ~deny;
			acc_resp_o.force_ff <= acc_req_i.valid & deny & acc_req_i.dma
				& ~acc_req_i.write;
		end
	end

endmodule : nvmp_unit

// ==== dv/nvmp_core_model.sv ====
// core and dma requester model driving the access port
`timescale 1ns/1ps
module nvmp_core_model
	import nvmp_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic go_i, // issue one request
	input wire nvmp_acc_req_type cmd_i, // request to issue
	input wire nvmp_acc_resp_type acc_resp_i, // verdict from unit
	output nvmp_acc_req_type acc_req_o = '0, // request to unit
	output logic done_o, // verdict captured
	output logic grant_o, // captured grant
	output logic ff_o // captured all-ones flag
);
	// one-cycle request; idle address inverted so stale values never match
	always_ff @(posedge clk_i)
	begin
		if (go_i)
			acc_req_o <= cmd_i;
		else
			acc_req_o <= '{1'b0, 1'b0, 1'b0, ~acc_req_o.addr};
	end
	// capture the verdict of each request
	always_ff @(posedge clk_i)
	begin
		done_o <= acc_resp_i.done;
		if (acc_resp_i.done)
		begin
			grant_o <= acc_resp_i.grant;
			ff_o <= acc_resp_i.force_ff;
		end
	end
endmodule : nvmp_core_model

// ==== dv/nvmp_unit_monitor.sv ====
// checker for bus, access port and reset behaviour of the protection unit
`timescale 1ns/1ps
module nvmp_unit_monitor
	import nvmp_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic por_i, // stored clear
	input wire logic test_mode_i, // test mode
	input wire logic [23:0] fetch_addr_i, // fetch address
	input wire logic [25:0] wb_adr_i, // address
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [3:0] wb_sel_i, // selects
	input wire logic wb_we_i, // write
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // acknowledge
	input wire nvmp_acc_req_type acc_req_i, // access request
	input wire nvmp_acc_resp_type acc_resp_o, // access verdict
	input wire logic test_enable_o // test modes usable
);
	logic [1:0] run_cnt;
	// cycles since reset release, saturating once running
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			run_cnt <= 2'h0;
		else if (run_cnt != 2'h3)
			run_cnt <= run_cnt + 2'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// bus request taken, and a read of a password byte
	sequence wb_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence pwd_take;
		wb_take ##0 (!wb_we_i && (wb_adr_i[25:2] == IDX_PASSWORD_LO ||
			wb_adr_i[25:2] == IDX_PASSWORD_HI));
	endsequence
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |=>
		!wb_ack_o && acc_resp_o == 3'h0 && !test_enable_o) else $error("outputs not quiet in reset");
	ack_next_a: assert property (wb_take |=> wb_ack_o) else $error("ack missing");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	pwd_read_a: assert property (pwd_take |=> wb_ack_o && wb_dat_o[7:0] == PASSWORD_READ)
		else $error("password byte readable");
	resp_next_a: assert property (acc_req_i.valid && run_cnt == 2'h3 |=> acc_resp_o.done)
		else $error("access verdict missing");
	dma_ff_a: assert property (acc_resp_o.done && run_cnt == 2'h3 |-> acc_resp_o.force_ff ==
		(!acc_resp_o.grant && $past(acc_req_i.dma) && !$past(acc_req_i.write)))
		else $error("all-ones substitution wrong");
	test_write_a: assert property (acc_req_i.valid && acc_req_i.write && !test_mode_i &&
		acc_req_i.addr >= TEST_BASE && acc_req_i.addr <= TEST_CODE_LAST |=> !acc_resp_o.grant)
		else $error("test area write granted");
	bypass_a: assert property (acc_req_i.valid && test_mode_i && test_enable_o &&
		run_cnt == 2'h3 |=> acc_resp_o.grant) else $error("test mode bypass missing");
endmodule : nvmp_unit_monitor

bind nvmp_unit nvmp_unit_monitor i_nvmp_unit_monitor (.clk_i(clk_i), .rst_i(rst_i),
	.por_i(por_i), .test_mode_i(test_mode_i), .fetch_addr_i(fetch_addr_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .acc_req_i(acc_req_i),
	.acc_resp_o(acc_resp_o), .test_enable_o(test_enable_o));

// ==== dv/nvmp_unit_tb.sv ====
// self-checking bench for the memory protection unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end
module nvmp_unit_tb
	import nvmp_pkg::*;
;
	logic clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, test_mode_i = 1'b0, go = 1'b0;
	logic [23:0] fetch_addr_i = RAM_BASE;
	logic [25:0] wb_adr_i = '0;
	logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
	logic [3:0] wb_sel_i = '0;
	logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o, test_enable_o;
	logic grant, ff, done;
	logic [23:0] bad [2] = '{24'h000100, 24'h230100};
	nvmp_acc_req_type acc_req_i, cmd = '0;
	nvmp_acc_resp_type acc_resp_o;
	int miscompares = 0, checked = 0;
	// 200 MHz clock
	always #2.5 clk_i = ~clk_i;
	nvmp_unit i_nvmp_unit (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .test_mode_i(test_mode_i),
		.fetch_addr_i(fetch_addr_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .acc_req_i(acc_req_i), .acc_resp_o(acc_resp_o),
		.test_enable_o(test_enable_o));
	nvmp_core_model i_nvmp_core_model (.clk_i(clk_i), .go_i(go), .cmd_i(cmd),
		.acc_resp_i(acc_resp_o), .acc_req_o(acc_req_i), .done_o(done), .grant_o(grant), .ff_o(ff));
	task automatic end_of_test();
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic rst_pulse();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : rst_pulse
	// one classic cycle; request held until ack is sampled
	task automatic wb_xfer(input logic [23:0] f, input logic we, input logic [23:0] idx,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		fetch_addr_i <= f;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'h0};
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge clk_i);
		end
		if (wb_ack_o !== 1'b1)
			miscompares++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb_xfer
	task automatic chk_rd(input logic [23:0] idx, input logic [7:0] e);
		wb_xfer(RAM_BASE, 1'b0, idx, 32'h0);
		`CHK("reg", e, rd[7:0])
	endtask : chk_rd
	task automatic ps(input logic [23:0] f, input logic [1:0] t, input logic [15:0] d);
		wb_xfer(f, 1'b1, IDX_PSET_CMD, {14'h0, t, d});
	endtask : ps
	task automatic chk_te(input logic e);
		repeat (2) @(negedge clk_i);
		`CHK("test_enable", e, test_enable_o)
	endtask : chk_te
	// one operand request through the core model, verdict compared
	task automatic acc(input logic [23:0] f, input logic w, input logic d, input logic [23:0] a,
		input logic eg, input logic ef);
		int n;
		n = 0;
		@(posedge clk_i);
		fetch_addr_i <= f;
		go <= 1'b1;
		cmd <= '{1'b1, w, d, a};
		@(posedge clk_i);
		go <= 1'b0;
		while (done !== 1'b1 && n < 10)
		begin
			n++;
			@(posedge clk_i);
		end
		if (done !== 1'b1)
			miscompares++;
		`CHK("grant", eg, grant)
		`CHK("force_ff", ef, ff)
	endtask : acc
	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		end_of_test();
	end
	// main sequence
	initial
	begin
		rst_pulse();
		chk_rd(IDX_ACCESS_NV, 8'hFF);
		chk_rd(IDX_WRITE_NV, 8'hFF);
		chk_rd(IDX_PASSWORD_LO, 8'hFF);
		chk_rd(IDX_PASSWORD_HI, 8'hFF);
		chk_rd(24'h000010, 8'h00);
		wb_xfer(RAM_BASE, 1'b1, IDX_WRITE_NV, 32'h0);
		chk_rd(IDX_WRITE_NV, 8'hFF);
		foreach (bad[i])
		begin
			ps(bad[i], TGT_WRITE, 16'h00E0);
			chk_rd(IDX_PSET_STATUS, 8'h02);
		end
		ps(RAM_BASE, TGT_WRITE, 16'h00E0);
		chk_rd(IDX_WRITE_NV, 8'hE0);
		for (int s = 0; s < 4; s++)
			acc(RAM_BASE, 1'b1, 1'b0, 24'(s) << SECTOR_SHIFT, 1'b0, 1'b0);
		acc(RAM_BASE, 1'b1, 1'b0, EEPROM_BASE, 1'b0, 1'b0);
		acc(RAM_BASE, 1'b1, 1'b0, RAM_BASE, 1'b1, 1'b0);
		ps(RAM_BASE, TGT_WRITE, 16'h00FF);
		chk_rd(IDX_WRITE_NV, 8'hFF);
		acc(RAM_BASE, 1'b1, 1'b0, 24'h010000, 1'b1, 1'b0);
		acc(RAM_BASE, 1'b1, 1'b0, EEPROM_BASE, 1'b1, 1'b0);
		rst_pulse();
		chk_rd(IDX_WRITE_NV, 8'hE0);
		ps(RAM_BASE, 2'h3, 16'h0000);
		chk_rd(IDX_PSET_STATUS, 8'h01);
		chk_rd(IDX_WRITE_NV, 8'hE0);
		ps(RAM_BASE, TGT_ACCESS, 16'h00BF);
		chk_rd(IDX_ACCESS_NV, 8'hBF);
		acc(RAM_BASE, 1'b0, 1'b0, 24'h000200, 1'b0, 1'b0);
		acc(RAM_BASE, 1'b0, 1'b1, 24'h000200, 1'b0, 1'b1);
		acc(24'h000100, 1'b0, 1'b0, 24'h000200, 1'b1, 1'b0);
		wb_xfer(RAM_BASE, 1'b1, IDX_ACCESS_NV, 32'h40);
		chk_rd(IDX_ACCESS_NV, 8'hBF);
		wb_xfer(24'h000100, 1'b1, IDX_ACCESS_NV, 32'h40);
		chk_rd(IDX_ACCESS_NV, 8'hFF);
		acc(RAM_BASE, 1'b0, 1'b1, 24'h000200, 1'b1, 1'b0);
		ps(RAM_BASE, TGT_ACCESS, 16'h00BF);
		chk_rd(IDX_ACCESS_NV, 8'hBF);
		ps(RAM_BASE, TGT_ACCESS, 16'h00F7);
		chk_rd(IDX_ACCESS_NV, 8'hB7);
		acc(24'h400000, 1'b0, 1'b0, RAM_BASE, 1'b0, 1'b0);
		acc(RAM_BASE, 1'b0, 1'b0, RAM_BASE, 1'b1, 1'b0);
		ps(24'h400000, TGT_ACCESS, 16'h00FF);
		chk_rd(IDX_ACCESS_NV, 8'hB7);
		ps(RAM_BASE, TGT_ACCESS, 16'h00FF);
		chk_rd(IDX_ACCESS_NV, 8'hBF);
		ps(RAM_BASE, TGT_ACCESS, 16'h00EF);
		acc(RAM_BASE, 1'b0, 1'b0, EEPROM_BASE, 1'b0, 1'b0);
		ps(RAM_BASE, TGT_ACCESS, 16'h00FF);
		chk_rd(IDX_ACCESS_NV, 8'hAF);
		ps(EEPROM_BASE + 24'h10, TGT_ACCESS, 16'h00FF);
		chk_rd(IDX_ACCESS_NV, 8'hBF);
		acc(RAM_BASE, 1'b1, 1'b0, TEST_BASE + 24'h100, 1'b0, 1'b0);
		test_mode_i <= 1'b1;
		acc(RAM_BASE, 1'b1, 1'b0, 24'h010000, 1'b1, 1'b0);
		ps(RAM_BASE, TGT_PASSWORD, 16'h5AA5);
		chk_rd(IDX_WRITE_NV, 8'h60);
		chk_te(1'b0);
		acc(RAM_BASE, 1'b1, 1'b0, 24'h010000, 1'b0, 1'b0);
		ps(RAM_BASE, TGT_PASSWORD, 16'h1234);
		chk_rd(IDX_ACCESS_NV, 8'hBB);
		ps(RAM_BASE, TGT_PASSWORD, 16'h5AA5);
		chk_rd(IDX_WRITE_NV, 8'h20);
		chk_te(1'b1);
		acc(RAM_BASE, 1'b1, 1'b0, 24'h010000, 1'b1, 1'b0);
		ps(RAM_BASE, TGT_PASSWORD, 16'h1234);
		ps(RAM_BASE, TGT_PASSWORD, 16'h4321);
		ps(RAM_BASE, TGT_PASSWORD, 16'h5AA5);
		chk_rd(IDX_ACCESS_NV, 8'hB8);
		chk_te(1'b0);
		end_of_test();
	end
endmodule : nvmp_unit_tb
